// file: rtl/flash_seq.sv
`timescale 1ns/1ns
module flash_seq #(
	parameter int PAGE_CYC  = flash_seq_pkg::PAGE_WRITE_TIME_US * flash_seq_pkg::CLK_MHZ,
	parameter int SMALL_CYC = flash_seq_pkg::SMALL_UNIT_WIPE_TIME_US * flash_seq_pkg::CLK_MHZ,
	parameter int BLOCK_CYC = flash_seq_pkg::BLOCK_WIPE_TIME_US * flash_seq_pkg::CLK_MHZ,
	parameter int ARRAY_CYC = flash_seq_pkg::ARRAY_WIPE_TIME_US * flash_seq_pkg::CLK_MHZ
) (
	input  wire logic                        clk_i,
	input  wire logic                        rstn_i,
	input  wire logic                        sclk_i,
	input  wire logic                        cs_n_i,
	input  wire logic [3:0]                  io_i,
	output logic [3:0]                       io_o,
	output logic [3:0]                       io_oe_o,
	input  wire flash_seq_pkg::status_cfg_t  cfg_i,
	output logic                             write_in_progress_o,
	output logic                             write_enable_latch_o,
	output logic                             sleep_o,
	output logic                             standby_o,
	output flash_seq_pkg::prog_t             prog_o,
	output flash_seq_pkg::wipe_t             wipe_o
);
	import flash_seq_pkg::*;

	// ****************************************************************
	// Link side, clocked by the host's serial clock
	// ****************************************************************
	logic        in_frame_reg;
	logic [15:0] edges_reg;
	logic [7:0]  opcode_reg;
	logic [23:0] addr_reg;
	logic [3:0]  hi_nib_reg;
	logic [7:0]  bidx_reg;
	logic [255:0] mask_reg;
	logic [7:0]  page_buf [256];
	logic        busy_l1_reg;
	logic        busy_l2_reg;

	wire  [15:0] e_cur     = in_frame_reg ? edges_reg : 16'h0000;
	wire  [7:0]  bidx_cur  = in_frame_reg ? bidx_reg : 8'h00;
	wire  [15:0] dpos      = 16'(e_cur - ADDR_END_EDGES);
	wire         in_op     = e_cur < OPCODE_EDGES;
	wire         in_addr   = !in_op && e_cur < ADDR_END_EDGES;
	wire         in_data   = !in_op && !in_addr;
	// A frame during a running cycle must not disturb the page being walked out
	wire         byte_done = in_data && dpos[0] && opcode_reg == OP_QUAD_PAGE_WRITE && !busy_l2_reg;
	wire  [7:0]  buf_idx   = 8'(addr_reg[7:0] + bidx_cur);
	wire  [15:0] edges_next = (e_cur == EDGE_CNT_MAX) ? EDGE_CNT_MAX : 16'(e_cur + 16'h0001);
	wire         first_byte = dpos == 16'h0001;
	wire  [255:0] byte_bit  = 256'(8'h01) << buf_idx;

	// Cleared by deselect so that the next frame restarts its counts
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i)
			in_frame_reg <= 1'b0;
		else
			in_frame_reg <= 1'b1;
	end

	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_l1_reg <= 1'b0;
			busy_l2_reg <= 1'b0;
		end else begin
			busy_l1_reg <= write_in_progress_o;
			busy_l2_reg <= busy_l1_reg;
		end
	end

	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			edges_reg  <= 16'h0000;
			opcode_reg <= 8'h00;
			addr_reg   <= 24'h00_0000;
			hi_nib_reg <= 4'h0;
			bidx_reg   <= 8'h00;
		end else begin
			edges_reg <= edges_next;
			bidx_reg  <= byte_done ? 8'(bidx_cur + 8'h01) : bidx_cur;
			if (in_op)
				opcode_reg <= {opcode_reg[6:0], io_i[0]};
			if (in_addr)
				addr_reg <= {addr_reg[22:0], io_i[0]};
			if (in_data && !dpos[0])
				hi_nib_reg <= io_i;
		end
	end

	// Late bytes overwrite early ones, so only the last 256 survive; the mask restarts at the
	// first byte of a frame, but byte_done is held low while busy, so a frame sent then leaves the running walk alone
	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i)
			mask_reg <= '0;
		else if (byte_done)
			mask_reg <= (first_byte ? '0 : mask_reg) | byte_bit;
	end

	always_ff @(posedge sclk_i) begin
		if (byte_done)
			page_buf[buf_idx] <= {hi_nib_reg, io_i};
	end

	// ****************************************************************
	// Core side
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROG,
		ST_WIPE,
		ST_SLEEP_WAIT,
		ST_SLEEP,
		ST_WAKE
	} state_t;

	function automatic logic addr_prot(input logic [23:0] a, input logic [4:0] bp, input logic cmp);
		logic [20:0] off;
		logic [20:0] units;
		logic [20:0] limit;
		logic        hit;
		off   = bp[3] ? a[20:0] : ~a[20:0];
		units = bp[4] ? (off >> PROT_SHIFT_FINE) : (off >> PROT_SHIFT_COARSE);
		limit = 21'h00_0001 << (bp[2:0] - 3'd1);
		hit   = (bp[2:0] != 3'd0) && (units < limit);
		return hit ^ cmp;
	endfunction

	// A region is edge anchored, so testing both ends of a span is enough
	function automatic logic span_prot(input logic [23:0] a, input logic [23:0] m, input status_cfg_t c);
		return addr_prot(a & ~m, c.block_protect_bits, c.protect_complement) ||
		       addr_prot(a | m, c.block_protect_bits, c.protect_complement);
	endfunction

	state_t      state_reg;
	state_t      state_next;
	logic        cs_s1_reg;
	logic        cs_s2_reg;
	logic        cs_s3_reg;
	logic        wel_reg;
	logic        wel_next;
	logic [31:0] tmr_reg;
	logic [31:0] tmr_next;
	logic [8:0]  widx_reg;
	logic [23:0] base_reg;
	wipe_kind_t  kind_reg;
	wipe_kind_t  kind_next;

	// Link registers are read only after deselect has been synchronised, so they are still
	wire         cs_rise   = cs_s2_reg && !cs_s3_reg;
	wire         idle      = state_reg == ST_IDLE;
	wire         busy      = state_reg == ST_PROG || state_reg == ST_WIPE;
	wire         one_byte  = edges_reg == OPCODE_EDGES;
	wire         addr_only = edges_reg == ADDR_END_EDGES;
	wire  [7:0]  op        = opcode_reg;
	wire         cmd_go    = cs_rise && idle;
	wire         is_small  = op == OP_SMALL_UNIT_WIPE;
	wire         is_b32    = op == OP_BLOCK32_WIPE;
	wire         is_b64    = op == OP_BLOCK64_WIPE;
	wire         is_arr    = op == OP_ARRAY_WIPE_A || op == OP_ARRAY_WIPE_B;
	wire  [23:0] wipe_mask = is_small ? SMALL_UNIT_MASK : (is_b32 ? BLOCK32_MASK : BLOCK64_MASK);
	wire         whole_byte = edges_reg >= DATA_MIN_EDGES && !edges_reg[0];
	wire         pp_prot   = span_prot(addr_reg, PAGE_MASK, cfg_i);
	wire         aw_prot   = span_prot(addr_reg, wipe_mask, cfg_i);
	wire         pp_go     = cmd_go && op == OP_QUAD_PAGE_WRITE && cfg_i.quad_io_enable && wel_reg && whole_byte &&
	                         !pp_prot;
	wire         aw_go     = cmd_go && (is_small || is_b32 || is_b64) && wel_reg && addr_only &&
	                         !aw_prot;
	wire         arr_open  = (cfg_i.block_protect_bits[2:0] == 3'b000 && !cfg_i.protect_complement) ||
	                         (cfg_i.block_protect_bits[2:0] == 3'b111 && cfg_i.protect_complement);
	wire         ar_go     = cmd_go && is_arr && wel_reg && one_byte && arr_open;
	wire         sl_go     = cmd_go && op == OP_LOWEST_POWER && one_byte;
	wire         wk_go     = cs_rise && state_reg == ST_SLEEP && op == OP_WAKE_AND_ID_READ &&
	                         edges_reg >= OPCODE_EDGES;
	wire         write_unlock_cmd_go   = cmd_go && op == OP_WRITE_UNLOCK && one_byte;
	wire         wrdi_go   = cmd_go && op == OP_WRITE_LOCK && one_byte;
	wire         walk_on   = state_reg == ST_PROG && !widx_reg[8];
	wire         tmr_done  = tmr_reg == TMR_RST;

	always_comb begin
		state_next = state_reg;
		tmr_next   = tmr_done ? TMR_RST : 32'(tmr_reg - 32'h0000_0001);
		kind_next  = kind_reg;
		wel_next   = wel_reg;
		if (write_unlock_cmd_go)
			wel_next = 1'b1;
		if (wrdi_go || busy)
			wel_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (pp_go) begin
					state_next = ST_PROG;
					tmr_next   = 32'(PAGE_CYC - 1);
				end else if (aw_go || ar_go) begin
					state_next = ST_WIPE;
					kind_next  = is_arr ? WIPE_ARRAY : (is_small ? WIPE_SMALL : (is_b32 ? WIPE_BLOCK32 : WIPE_BLOCK64));
					tmr_next   = is_arr ? 32'(ARRAY_CYC - 1) :
					             (is_small ? 32'(SMALL_CYC - 1) : 32'(BLOCK_CYC - 1));
				end else if (sl_go) begin
					state_next = ST_SLEEP_WAIT;
					tmr_next   = 32'(SLEEP_ENTRY_CYC - 1);
				end
			end
			ST_PROG: begin
				if (tmr_done && widx_reg[8])
					state_next = ST_IDLE;
			end
			ST_WIPE: begin
				if (tmr_done)
					state_next = ST_IDLE;
			end
			ST_SLEEP_WAIT: begin
				if (tmr_done)
					state_next = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wk_go) begin
					state_next = ST_WAKE;
					tmr_next   = 32'(WAKE_CYC - 1);
				end
			end
			ST_WAKE: begin
				if (tmr_done)
					state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n_i;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			tmr_reg   <= TMR_RST;
			wel_reg   <= WEL_RST;
			kind_reg  <= WIPE_SMALL;
			base_reg  <= 24'h00_0000;
		end else begin
			state_reg <= state_next;
			tmr_reg   <= tmr_next;
			wel_reg   <= wel_next;
			kind_reg  <= kind_next;
			if (cmd_go)
				base_reg <= addr_reg;
		end
	end

	// Page is walked once at the start of the cycle; the cycle is held until the 256-byte walk ends
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			widx_reg <= WIDX_RST;
		else if (pp_go)
			widx_reg <= WIDX_RST;
		else if (walk_on)
			widx_reg <= 9'(widx_reg + 9'h001);
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_o                 <= IO_RST;
			io_oe_o              <= IO_RST;
			write_in_progress_o  <= 1'b0;
			write_enable_latch_o <= WEL_RST;
			sleep_o              <= 1'b0;
			standby_o            <= 1'b0;
			prog_o               <= '0;
			wipe_o               <= '0;
		end else begin
			io_o                 <= IO_RST;
			io_oe_o              <= IO_RST;
			write_in_progress_o  <= state_next == ST_PROG || state_next == ST_WIPE;
			write_enable_latch_o <= wel_next;
			sleep_o              <= state_next == ST_SLEEP;
			standby_o            <= state_next == ST_IDLE && cs_s2_reg;
			prog_o.we            <= walk_on && mask_reg[widx_reg[7:0]];
			prog_o.addr          <= {base_reg[23:8], widx_reg[7:0]};
			prog_o.data          <= page_buf[widx_reg[7:0]];
			wipe_o.start         <= aw_go || ar_go;
			wipe_o.kind          <= kind_next;
			wipe_o.base          <= is_arr ? 24'h00_0000 : (addr_reg & ~wipe_mask);
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	chk_prog_sets_busy: assert property (pp_go |-> ##1 write_in_progress_o [*8])
		else $error("page write did not raise busy");
	chk_qe_gate: assert property (cs_rise && idle && op == OP_QUAD_PAGE_WRITE && !cfg_i.quad_io_enable
		|=> !write_in_progress_o)
		else $error("quad write ran with quad mode off");
	chk_latch_gate: assert property (cs_rise && idle && !wel_reg |=> !write_in_progress_o)
		else $error("write ran without the latch");
	chk_latch_clears: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o)
		else $error("latch still set after cycle");
	chk_byte_edge: assert property (cs_rise && idle && op == OP_QUAD_PAGE_WRITE && edges_reg[0]
		|=> !write_in_progress_o)
		else $error("page write ran on a partial byte");
	chk_wipe_edge: assert property (cs_rise && (is_small || is_b32 || is_b64) && !addr_only
		|=> !wipe_o.start)
		else $error("erase ran on a bad frame length");
	chk_array_prot: assert property (wipe_o.start && wipe_o.kind == WIPE_ARRAY |-> $past(arr_open))
		else $error("array erase ran while protected");
	chk_sleep_delay: assert property ($rose(sleep_o) |-> $past(state_reg) == ST_SLEEP_WAIT && $past(tmr_done))
		else $error("sleep entered without its delay");
	chk_sleep_deaf: assert property (state_reg == ST_SLEEP && cs_rise |=> !write_in_progress_o && !wipe_o.start)
		else $error("command acted during sleep");
	chk_busy_keeps: assert property (busy && !tmr_done && cs_rise && op == OP_LOWEST_POWER |=> busy && !sleep_o)
		else $error("sleep entry broke a running cycle");
	chk_prog_in_cycle: assert property (prog_o.we |-> write_in_progress_o)
		else $error("byte programmed outside a cycle");
	// A frame that lands mid-cycle must not start an erase
	chk_busy_deaf: assert property (busy && cs_rise |=> !wipe_o.start)
		else $error("command acted during a busy cycle");
	chk_wipe_prot: assert property (wipe_o.start && wipe_o.kind != WIPE_ARRAY |-> !$past(aw_prot))
		else $error("erase ran on a protected target");
	chk_wipe_latch: assert property (wipe_o.start |-> $past(wel_reg))
		else $error("erase ran without the latch");
	chk_wake_deaf: assert property (state_reg == ST_WAKE && cs_rise |=> $stable(wel_reg) && !write_in_progress_o)
		else $error("command acted before wake time");
	chk_page_prot: assert property (cmd_go && op == OP_QUAD_PAGE_WRITE && pp_prot |=> !write_in_progress_o)
		else $error("page write ran on a protected page");
	chk_page_fixed: assert property (prog_o.we |-> prog_o.addr[23:8] == base_reg[23:8])
		else $error("byte programmed outside its page");
	chk_start_pulse: assert property (wipe_o.start |=> !wipe_o.start && write_in_progress_o)
		else $error("erase start not a single pulse");

	cov_page_write: cover property (pp_go ##1 write_in_progress_o);
	cov_wipe: cover property (wipe_o.start);
	cov_sleep: cover property ($rose(sleep_o));
	cov_wake: cover property (state_reg == ST_WAKE ##1 state_reg == ST_IDLE);
	cov_busy_reject: cover property (busy && cs_rise);

endmodule // flash_seq

// file: rtl/flash_seq_pkg.sv
// ****************************************************************
// Constants and types
// ****************************************************************
package flash_seq_pkg;

	localparam int CLK_NS  = 10;
	localparam int CLK_MHZ = 100;

	// Command codes
	localparam logic [7:0] OP_WRITE_UNLOCK     = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK       = 8'h04;
	localparam logic [7:0] OP_QUAD_PAGE_WRITE  = 8'h32;
	localparam logic [7:0] OP_SMALL_UNIT_WIPE  = 8'h20;
	localparam logic [7:0] OP_BLOCK32_WIPE     = 8'h52;
	localparam logic [7:0] OP_BLOCK64_WIPE     = 8'hd8;
	localparam logic [7:0] OP_ARRAY_WIPE_A     = 8'h60;
	localparam logic [7:0] OP_ARRAY_WIPE_B     = 8'hc7;
	localparam logic [7:0] OP_LOWEST_POWER     = 8'hb9;
	localparam logic [7:0] OP_WAKE_AND_ID_READ = 8'hab;

	// Frame positions in link clock edges
	localparam logic [15:0] OPCODE_EDGES   = 16'h0008;
	localparam logic [15:0] ADDR_END_EDGES = 16'h0020;
	localparam logic [15:0] DATA_MIN_EDGES = 16'h0022;
	localparam logic [15:0] EDGE_CNT_MAX   = 16'hffff;

	// Target spans, as masks of the low address bits; protection unit sizes, as shifts
	localparam logic [23:0] PAGE_MASK       = 24'h00_00ff;
	localparam logic [23:0] SMALL_UNIT_MASK = 24'h00_0fff;
	localparam logic [23:0] BLOCK32_MASK    = 24'h00_7fff;
	localparam logic [23:0] BLOCK64_MASK    = 24'h00_ffff;
	localparam int          PROT_SHIFT_FINE   = 12;
	localparam int          PROT_SHIFT_COARSE = 16;

	// Self-timed durations
	localparam int PAGE_WRITE_TIME_US      = 600;
	localparam int SMALL_UNIT_WIPE_TIME_US = 50000;
	localparam int BLOCK_WIPE_TIME_US      = 200000;
	localparam int ARRAY_WIPE_TIME_US      = 8000000;
	localparam int SLEEP_ENTRY_DELAY_NS    = 3000;
	localparam int WAKE_TIME_NS            = 3000;
	localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC        = (WAKE_TIME_NS + CLK_NS - 1) / CLK_NS;

	// Values after reset
	localparam logic        WEL_RST   = 1'b0;
	localparam logic [3:0]  IO_RST    = 4'h0;
	localparam logic [31:0] TMR_RST   = 32'h0000_0000;
	localparam logic [8:0]  WIDX_RST  = 9'h000;

	typedef enum logic [1:0] {
		WIPE_SMALL,
		WIPE_BLOCK32,
		WIPE_BLOCK64,
		WIPE_ARRAY
	} wipe_kind_t;

	typedef struct packed {
		logic        we;
		logic [23:0] addr;
		logic [7:0]  data;
	} prog_t;

	typedef struct packed {
		logic        start;
		wipe_kind_t  kind;
		logic [23:0] base;
	} wipe_t;

	typedef struct packed {
		logic [4:0] block_protect_bits;
		logic       protect_complement;
		logic       quad_io_enable;
	} status_cfg_t;

endpackage

// file: tb/spi_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host side of the link: one frame per call
// ****************************************************************
module spi_host_model (
	output logic       sclk_o,
	output logic [3:0] io_o,
	output logic       cs_n_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o   = 4'h0;
	end

	// Clock only toggles inside a frame; lines flip on release so a stale value is never read
	task automatic frame(input logic [3:0] ed[$]);
		cs_n_o = 1'b0;
		#5;
		foreach (ed[i]) begin
			io_o = ed[i];
			#7 sclk_o = 1'b1;
			#8 sclk_o = 1'b0;
		end
		#5 cs_n_o = 1'b1;
		io_o = ~io_o;
	endtask
endmodule // spi_host_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	import flash_seq_pkg::*;
	typedef struct {
		logic [7:0]  op;
		logic [23:0] a;
		status_cfg_t cfg;
		bit          go;
		wipe_kind_t  k;
		logic [23:0] b;
		int          cyc;
	} row_t;

	logic        clk_i  = 1'b0;
	logic        rstn_i = 1'b0;
	logic        sclk, cs_n, write_in_progress, write_enable_latch, slp, stby;
	logic [3:0]  io_in, io_out, io_oe;
	status_cfg_t cfg = '0;
	prog_t       prog;
	wipe_t       wipe;
	int          num_errors = 0;
	int          checks = 0;
	int          n;
	logic [3:0]  q[$];
	logic [8:0]  exp_pg[256];
	row_t        rows[9];

	always #5 clk_i = ~clk_i;

	spi_host_model u_host (.sclk_o(sclk), .io_o(io_in), .cs_n_o(cs_n));
	flash_seq #(.PAGE_CYC(300), .SMALL_CYC(60), .BLOCK_CYC(80), .ARRAY_CYC(100)) u_dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_in), .io_o(io_out),
		.io_oe_o(io_oe), .cfg_i(cfg), .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch),
		.sleep_o(slp), .standby_o(stby), .prog_o(prog), .wipe_o(wipe));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic complete_run();
		$display("Counts: %0d checks, %0d errors", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic put_byte(input logic [7:0] b, input bit quad);
		if (quad) begin
			q.push_back(b[7:4]);
			q.push_back(b[3:0]);
		end else begin
			for (int i = 7; i >= 0; i--) q.push_back({3'b000, b[i]});
		end
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit addr);
		put_byte(op, 1'b0);
		if (addr) begin
			put_byte(a[23:16], 1'b0);
			put_byte(a[15:8], 1'b0);
			put_byte(a[7:0], 1'b0);
		end
	endtask

	task automatic send(input int gap);
		u_host.frame(q);
		q = {};
		repeat (gap) @(negedge clk_i);
	endtask

	task automatic wait_start(output bit seen);
		seen = 0;
		repeat (12) begin
			@(negedge clk_i);
			if (wipe.start === 1'b1) begin
				seen = 1;
				break;
			end
		end
	endtask

	task automatic count_wip(output int cnt);
		cnt = 0;
		while (write_in_progress === 1'b1 && cnt < 3000) begin
			cnt++;
			@(negedge clk_i);
		end
		if (cnt == 3000) begin
			num_errors++;
			$display("Error busy wait expected end seen timeout");
			complete_run();
		end
	endtask

	task automatic page(input logic [23:0] a, input int nb, input bit odd, input bit go);
		int  cnt;
		int  pulses;
		int  want;
		bit  seen;
		want = 0;
		pulses = 0;
		seen = 0;
		foreach (exp_pg[j]) exp_pg[j] = 9'h000;
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		cmd(OP_QUAD_PAGE_WRITE, a, 1);
		for (int k = 0; k < nb; k++) begin
			put_byte(8'(k * 7 + 3), 1'b1);
			exp_pg[8'(a[7:0] + k)] = {1'b1, 8'(k * 7 + 3)};
		end
		if (odd) q.push_back(4'h5);
		send(0);
		foreach (exp_pg[j]) want += exp_pg[j][8];
		repeat (12) begin
			@(negedge clk_i);
			if (write_in_progress === 1'b1) begin
				seen = 1;
				break;
			end
		end
		`CHK("page run", go, seen)
		cnt = 0;
		while (seen && write_in_progress === 1'b1 && cnt < 3000) begin
			cnt++;
			if (prog.we === 1'b1) begin
				pulses++;
				`CHK("page", a[23:8], prog.addr[23:8])
				`CHK("data", exp_pg[prog.addr[7:0]], {1'b1, prog.data})
				exp_pg[prog.addr[7:0]] = 9'h000;
			end
			@(negedge clk_i);
		end
		if (seen) begin
			`CHK("byte count", want, pulses)
			`CHK("page cycles", 300, cnt)
			`CHK("latch cleared", 1'b0, write_enable_latch)
		end
		$display("Page test at %0h done", a);
		repeat (6) @(negedge clk_i);
	endtask

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		bit seen;
		rows[0] = '{OP_SMALL_UNIT_WIPE, 24'h12_3456, 7'h00, 1, WIPE_SMALL, 24'h12_3000, 60};
		rows[1] = '{OP_BLOCK32_WIPE, 24'h12_9abc, 7'h00, 1, WIPE_BLOCK32, 24'h12_8000, 80};
		rows[2] = '{OP_BLOCK64_WIPE, 24'h12_9abc, 7'h00, 1, WIPE_BLOCK64, 24'h12_0000, 80};
		rows[3] = '{OP_ARRAY_WIPE_A, 24'h00_0000, 7'h00, 1, WIPE_ARRAY, 24'h00_0000, 100};
		rows[4] = '{OP_ARRAY_WIPE_B, 24'h00_0000, 7'h1e, 1, WIPE_ARRAY, 24'h00_0000, 100};
		rows[5] = '{OP_ARRAY_WIPE_B, 24'h00_0000, 7'h04, 0, WIPE_ARRAY, 24'h00_0000, 0};
		rows[6] = '{OP_SMALL_UNIT_WIPE, 24'h00_0000, 7'h02, 0, WIPE_SMALL, 24'h00_0000, 0};
		rows[7] = '{OP_SMALL_UNIT_WIPE, 24'h1f_0000, 7'h04, 0, WIPE_SMALL, 24'h00_0000, 0};
		rows[8] = '{OP_SMALL_UNIT_WIPE, 24'h01_5abc, 7'h04, 1, WIPE_SMALL, 24'h01_5000, 60};
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		`CHK("standby", 1'b1, stby)
		`CHK("sleep", 1'b0, slp)
		`CHK("busy", 1'b0, write_in_progress)
		`CHK("latch", 1'b0, write_enable_latch)
		$display("Reset test done");
		foreach (rows[i]) begin
			cfg = rows[i].cfg;
			cmd(OP_WRITE_UNLOCK, 0, 0);
			send(6);
			`CHK("latch set", 1'b1, write_enable_latch)
			cmd(rows[i].op, rows[i].a, rows[i].k != WIPE_ARRAY);
			send(0);
			wait_start(seen);
			`CHK("erase run", rows[i].go, seen)
			if (seen) begin
				`CHK("kind", rows[i].k, wipe.kind)
				if (rows[i].k != WIPE_ARRAY) `CHK("base", rows[i].b, wipe.base)
				count_wip(n);
				`CHK("busy cycles", rows[i].cyc, n)
				`CHK("latch cleared", 1'b0, write_enable_latch)
			end
			$display("Row %0d done", i);
			repeat (6) @(negedge clk_i);
		end
		cfg = 7'h00;
		cmd(OP_WRITE_LOCK, 0, 0);
		send(6);
		cmd(OP_SMALL_UNIT_WIPE, 24'h00_1000, 1);
		send(0);
		wait_start(seen);
		`CHK("erase unlatched", 1'b0, seen)
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		cmd(OP_SMALL_UNIT_WIPE, 24'h00_1000, 1);
		void'(q.pop_back());
		send(0);
		wait_start(seen);
		`CHK("erase short", 1'b0, seen)
		`CHK("latch kept", 1'b1, write_enable_latch)
		$display("Refusal tests done");
		cfg = 7'h01;
		page(24'h00_12fe, 3, 0, 1);
		page(24'h00_3400, 258, 0, 1);
		page(24'h00_5600, 3, 1, 0);
		cfg = 7'h05;
		page(24'h1f_0000, 3, 0, 0);
		cfg = 7'h00;
		page(24'h00_5600, 3, 0, 0);
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		cmd(OP_SMALL_UNIT_WIPE, 24'h00_2000, 1);
		send(0);
		wait_start(seen);
		fork
			count_wip(n);
			begin
				cmd(OP_LOWEST_POWER, 0, 0);
				send(0);
			end
		join
		`CHK("busy cycles", 60, n)
		repeat (320) @(negedge clk_i);
		`CHK("no sleep", 1'b0, slp)
		`CHK("standby idle", 1'b1, stby)
		$display("Busy test done");
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		cmd(OP_LOWEST_POWER, 0, 0);
		send(6);
		`CHK("standby left", 1'b0, stby)
		repeat (280) @(negedge clk_i);
		`CHK("sleep early", 1'b0, slp)
		repeat (30) @(negedge clk_i);
		`CHK("sleep", 1'b1, slp)
		cmd(OP_WRITE_LOCK, 0, 0);
		send(6);
		`CHK("latch in sleep", 1'b1, write_enable_latch)
		cmd(OP_WAKE_AND_ID_READ, 0, 0);
		send(6);
		`CHK("woken", 1'b0, slp)
		cmd(OP_WRITE_LOCK, 0, 0);
		send(6);
		`CHK("latch while waking", 1'b1, write_enable_latch)
		repeat (310) @(negedge clk_i);
		`CHK("standby back", 1'b1, stby)
		cmd(OP_WRITE_LOCK, 0, 0);
		send(6);
		`CHK("latch after wake", 1'b0, write_enable_latch)
		$display("Sleep test done");
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		cmd(OP_SMALL_UNIT_WIPE, 24'h00_3000, 1);
		send(0);
		wait_start(seen);
		`CHK("erase before reset", 1'b1, seen)
		rstn_i = 1'b0;
		repeat (8) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (4) @(negedge clk_i);
		`CHK("busy after reset", 1'b0, write_in_progress)
		`CHK("standby after reset", 1'b1, stby)
		`CHK("io drive", 8'h00, {io_oe, io_out})
		cmd(OP_WRITE_UNLOCK, 0, 0);
		send(6);
		`CHK("latch after reset", 1'b1, write_enable_latch)
		$display("Mid-run reset test done");
		complete_run();
	end
endmodule // testbench
